// [hw/psc_cfg_regs.sv]
// Configuration and command register bank of the PSI5 receiver
// Overview of operation
// - Bootstrap off bit: 0 enabled, 1 disabled.
// - Per slot check select: 0 CRC, 1 parity.
// - Bit count codes 8 to 28 direct, else 20.
// - Slot 1 settings shared: init, simple, async.
// - While shared, other slot registers keep values.
// - Five-bit sensor identifiers, three per register.
// - Six 12-bit slot start times, microsecond steps.
// - Twelve-bit end time of the last slot.
// - Reset needs 0x5555 then 0xA5A5 next frame.
// - 0x00FF or 0xFF00 clears upstream buffer, ready.
// - 0x1111 locks programming registers, clears phase.
// - 0x9999 grants self-test writes, 0x9090 revokes.
// - Command register write-only, value triggers action.
// - Pulse step select: 0 is 2.5 V, 1 3.5 V.
// - Output pin role: 0 data, 1 interrupt.
// - Monitoring: 01 standard, 10 simple, else off.
// - Current limit: 00 19, 10 45, else 35 mA.
// - Init data bit stores init frames.
// - Slot count codes 1 to 6 direct, else 3.
// - Rate: 01 189k, 10 83.3k, else 125k.
// - Mode bit: 0 asynchronous, 1 synchronous.
`timescale 1ns/100ps
module psc_cfg_regs (
  // Clock and reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_N,
  // SPI link
  input  wire logic                    SPI_SCK,
  input  wire logic                    SPI_CS_N,
  input  wire logic                    SPI_MOSI,
  output logic                         SPI_MISO,
  output logic                         SPI_MISO_OE,
  // Channel 1 mode bits held in the core
  input  wire logic                    CH1_KEEP_INIT_FRAMES,
  input  wire logic [1:0]              CH1_SLOT_MONITOR_MODE,
  input  wire logic                    CH1_SYNCHRONOUS_ON,
  // Clock supervisor
  input  wire logic                    CLK_FAULT,
  // Channel 1 settings
  output logic                         CH1_BOOTSTRAP_OFF,
  output psc_pkg::psc_slot_t [3:0]     CH1_SLOT_CFG,
  output logic                         CH1_SLOT1_SHARED,
  output logic [5:0][4:0]              CH1_SENSOR_IDENT,
  output logic [5:0][11:0]             CH1_SLOT_OPEN_TIME,
  output logic [11:0]                  CH1_LAST_SLOT_CLOSE_TIME,
  // Channel 2 settings
  output psc_pkg::psc_volt_t           CH2_PULSE_STEP_VOLT,
  output psc_pkg::psc_role_t           CH2_OUT_PIN_ROLE,
  output psc_pkg::psc_mon_t            CH2_SLOT_MONITOR_MODE,
  output psc_pkg::psc_cur_t            CH2_IDLE_CURRENT_LIMIT,
  output logic                         CH2_KEEP_INIT_FRAMES,
  output logic [2:0]                   CH2_SLOT_COUNT,
  output psc_pkg::psc_rate_t           CH2_BIT_RATE,
  output logic                         CH2_SYNCHRONOUS_ON,
  // Command effects
  output logic                         SOFTWARE_TRIGGERED_RESET,
  output logic                         CH1_UPSTREAM_CLEAR,
  output logic                         CH2_UPSTREAM_CLEAR,
  output logic                         PROG_PHASE,
  output logic                         SELFTEST_PROG_WE,
  output logic                         SELFTEST_RUN_WE,
  output logic                         SELFTEST_WRITE_ALLOWED
);

  // ======
  // Decoding functions
  // Codes out of range default
  // Data bit count from a five-bit code
  function automatic logic [4:0] bit_count(input logic [4:0] code);
    logic ok;
    ok = (code >= psc_pkg::BITS_MIN) && (code <= psc_pkg::BITS_MAX);
    return ok ? code : psc_pkg::BITS_DEF;
  endfunction

  // Slot count from a three-bit code
  function automatic logic [2:0] slot_count(input logic [2:0] code);
    logic ok;
    ok = (code >= psc_pkg::SLOTS_MIN) && (code <= psc_pkg::SLOTS_MAX);
    return ok ? code : psc_pkg::SLOTS_DEF;
  endfunction

  // Monitoring mode from its two-bit code
  function automatic psc_pkg::psc_mon_t mon_mode(input logic [1:0] code);
    psc_pkg::psc_mon_t m;
    m = psc_pkg::MON_OFF;
    case (code)
      psc_pkg::MON_CODE_STD:    m = psc_pkg::MON_STD;
      psc_pkg::MON_CODE_SIMPLE: m = psc_pkg::MON_SIMPLE;
      default:                  m = psc_pkg::MON_OFF;
    endcase
    return m;
  endfunction

  // Storage index lookup, hit flag on top
  function automatic logic [4:0] lookup(input logic [5:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < psc_pkg::REG_N; i++) begin
      if (a == psc_pkg::REG_ADDR[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // ======
  // State
  // All on the system clock
  logic [15:0] regs_reg [psc_pkg::REG_N]; // Configuration words
  logic        unlock_reg;       // Reset unlock seen last frame
  logic        prog_reg;         // Programming phase open
  logic        st_prog_we_reg;   // Prog-time self-test writable
  logic        st_run_we_reg;    // Run-time self-test writable
  logic        sw_rst_reg;       // Software reset pulse
  logic        clr1_reg;         // Channel 1 buffer clear pulse
  logic        clr2_reg;         // Channel 2 buffer clear pulse
  logic [5:0]  resp_addr_reg;    // Address of last frame
  logic [15:0] resp_data_reg;    // Read data of last frame

  // ======
  // Link
  // Frames arrive already crossed
  psc_pkg::psc_frame_t rx_frame; // Frame from the link
  logic                rx_valid; // One-cycle frame strobe
  psc_pkg::psc_resp_t  tx_resp;  // Answer for the next frame

  psc_spi_link u_link (
    .clk_sys  (CLK_SYS),
    .rst_n    (RST_N),
    .sck      (SPI_SCK),
    .cs_n     (SPI_CS_N),
    .mosi     (SPI_MOSI),
    .miso     (SPI_MISO),
    .miso_oe  (SPI_MISO_OE),
    .rx_frame (rx_frame),
    .rx_valid (rx_valid),
    .tx_resp  (tx_resp)
  );

  // ======
  // Frame decode
  // Valid in the strobe cycle
  wire [4:0]  look     = lookup(rx_frame.addr);
  wire        hit      = look[4];             // Address is a register
  wire [3:0]  idx      = look[3:0];           // Storage index
  wire [15:0] cmd      = rx_frame.data;       // Written value
  wire        is_wr    = rx_valid & rx_frame.wr;
  wire        dcr_wr   = is_wr & (rx_frame.addr == psc_pkg::ADDR_DCR);
  wire        cfg_wr   = is_wr & hit & prog_reg;
  wire        cmd_rst  = dcr_wr & (cmd == psc_pkg::CMD_RESET);
  wire        cmd_unl  = dcr_wr & (cmd == psc_pkg::CMD_UNLOCK);
  wire        cmd_clr1 = dcr_wr & (cmd == psc_pkg::CMD_CLR_CH1);
  wire        cmd_clr2 = dcr_wr & (cmd == psc_pkg::CMD_CLR_CH2);
  wire        cmd_eop  = dcr_wr & (cmd == psc_pkg::CMD_EOP);
  wire        cmd_ston = dcr_wr & (cmd == psc_pkg::CMD_ST_ON);
  wire        cmd_stof = dcr_wr & (cmd == psc_pkg::CMD_ST_OFF);
  wire        sw_rst   = cmd_rst & unlock_reg;
  // Any device reset restores the bank
  wire        bank_clr = ~RST_N | CLK_FAULT | sw_rst;
  // Command register holds nothing and reads as zero
  wire [15:0] rd_word  = hit ? regs_reg[idx] : 16'h0000;

  // ======
  // Slot 1 sharing condition on channel 1
  wire ch1_simple = mon_mode(CH1_SLOT_MONITOR_MODE) == psc_pkg::MON_SIMPLE;
  wire shared = CH1_KEEP_INIT_FRAMES | ch1_simple
              | ~CH1_SYNCHRONOUS_ON;

  // ======
  // Register file
  // One word per process
  genvar gi;
  generate
    for (gi = 0; gi < psc_pkg::REG_N; gi++) begin : g_reg
      localparam logic [15:0] M = psc_pkg::REG_MASK[gi];
      wire        sel = cfg_wr & (idx == 4'(gi));
      wire        is_a = (gi == psc_pkg::IDX_CR2);
      wire        is_b = (gi == psc_pkg::IDX_CR3);
      // Writable bits, narrowed while slot 1 is shared
      wire [15:0] meff = (shared & is_b) ? 16'h0000 :
                         (shared & is_a) ? (M & ~psc_pkg::SLOT2_MASK) :
                         M;
      // Store masked write data
      always_ff @(posedge CLK_SYS) begin
        if (bank_clr) begin
          regs_reg[gi] <= psc_pkg::REG_RESET[gi];
        end else if (sel) begin
          regs_reg[gi] <= (regs_reg[gi] & ~meff) | (cmd & meff);
        end
      end
    end
  endgenerate

  // ======
  // Command flags
  // Command writes store nothing
  // Unlock lasts exactly one frame
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      unlock_reg <= 1'b0;
    end else if (rx_valid) begin
      unlock_reg <= cmd_unl;
    end
  end

  // Programming phase, closed by end of programming
  always_ff @(posedge CLK_SYS) begin
    if (bank_clr) begin
      prog_reg <= 1'b1;
    end else if (cmd_eop) begin
      prog_reg <= 1'b0;
    end
  end

  // Self-test write grants
  always_ff @(posedge CLK_SYS) begin
    if (bank_clr) begin
      st_prog_we_reg <= 1'b0;
      st_run_we_reg  <= 1'b0;
    end else if (cmd_ston) begin
      st_prog_we_reg <= prog_reg;
      st_run_we_reg  <= 1'b1;
    end else if (cmd_stof) begin
      st_prog_we_reg <= 1'b0;
      st_run_we_reg  <= 1'b0;
    end
  end

  // One-cycle action pulses
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sw_rst_reg <= 1'b0;
      clr1_reg   <= 1'b0;
      clr2_reg   <= 1'b0;
    end else begin
      sw_rst_reg <= sw_rst;
      clr1_reg   <= cmd_clr1;
      clr2_reg   <= cmd_clr2;
    end
  end

  // ======
  // Answer for the following frame
  // Frozen until the next frame
  always_ff @(posedge CLK_SYS) begin
    if (bank_clr) begin
      resp_addr_reg <= 6'h00;
      resp_data_reg <= 16'h0000;
    end else if (rx_valid) begin
      resp_addr_reg <= rx_frame.addr;
      resp_data_reg <= rd_word;
    end
  end

  assign tx_resp = psc_pkg::psc_resp_t'{
    marker: 1'b0,
    prog:   prog_reg,
    st_en:  st_prog_we_reg | st_run_we_reg,
    rsv:    7'h00,
    addr:   resp_addr_reg,
    data:   resp_data_reg};

  // ======
  // Channel 1 slot settings
  wire [15:0] cr2 = regs_reg[psc_pkg::IDX_CR2];
  assign CH1_BOOTSTRAP_OFF = cr2[psc_pkg::BOOT_OFF_BIT];
  assign CH1_SLOT1_SHARED  = shared;

  // Held slots are 1, 2, 5 and 6, two to a register
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      localparam int R = psc_pkg::IDX_CR2 + gi / 2;
      localparam int L = (gi % 2) * psc_pkg::SLOT_W;
      wire [5:0] own = regs_reg[R][L +: psc_pkg::SLOT_W];
      wire [5:0] one = cr2[psc_pkg::SLOT_W-1:0];
      // Slot 1 values stand in for the others while shared
      wire [5:0] src = (shared && gi != 0) ? one : own;
      assign CH1_SLOT_CFG[gi].check =
        psc_pkg::psc_check_t'(src[psc_pkg::CNT_W]);
      assign CH1_SLOT_CFG[gi].bits =
        bit_count(src[psc_pkg::CNT_W-1:0]);
    end
  endgenerate

  // Identifiers and slot times
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sid
      localparam int R = psc_pkg::IDX_SID_LO + gi / 3;
      localparam int L = (gi % 3) * psc_pkg::SID_W;
      assign CH1_SENSOR_IDENT[gi] =
        regs_reg[R][L +: psc_pkg::SID_W];
      assign CH1_SLOT_OPEN_TIME[gi] =
        regs_reg[psc_pkg::IDX_ES1 + gi][psc_pkg::TIME_W-1:0];
    end
  endgenerate

  assign CH1_LAST_SLOT_CLOSE_TIME =
    regs_reg[psc_pkg::IDX_END][psc_pkg::TIME_W-1:0];

  // ======
  // Channel 2 general settings
  // Reserved bits never reach out
  wire [15:0] c2   = regs_reg[psc_pkg::IDX_CH2];
  wire [1:0]  curc = c2[psc_pkg::CUR_LSB +: 2];
  wire [1:0]  ratc = c2[psc_pkg::RATE_LSB +: 2];

  assign CH2_PULSE_STEP_VOLT = c2[psc_pkg::VSTEP_BIT] ?
    psc_pkg::VSTEP_3V5 : psc_pkg::VSTEP_2V5;
  assign CH2_OUT_PIN_ROLE = c2[psc_pkg::ROLE_BIT] ?
    psc_pkg::PIN_IRQ : psc_pkg::PIN_DATA;
  assign CH2_SLOT_MONITOR_MODE =
    mon_mode(c2[psc_pkg::MON_LSB +: 2]);
  // Current limit: two codes share the middle value
  assign CH2_IDLE_CURRENT_LIMIT =
    (curc == psc_pkg::CUR_CODE_19) ? psc_pkg::CUR_19MA :
    (curc == psc_pkg::CUR_CODE_45) ? psc_pkg::CUR_45MA :
    psc_pkg::CUR_35MA;
  assign CH2_KEEP_INIT_FRAMES = c2[psc_pkg::INIT_BIT];
  assign CH2_SLOT_COUNT =
    slot_count(c2[psc_pkg::SLOTS_LSB +: 3]);
  // Bit rate: two codes share the standard rate
  assign CH2_BIT_RATE =
    (ratc == psc_pkg::RATE_CODE_189) ? psc_pkg::RATE_189K :
    (ratc == psc_pkg::RATE_CODE_83)  ? psc_pkg::RATE_83K :
    psc_pkg::RATE_125K;
  assign CH2_SYNCHRONOUS_ON = c2[psc_pkg::SYNC_BIT];

  // ======
  // Command effects
  // One-cycle pulses and levels
  assign SOFTWARE_TRIGGERED_RESET = sw_rst_reg;
  assign CH1_UPSTREAM_CLEAR       = clr1_reg;
  assign CH2_UPSTREAM_CLEAR       = clr2_reg;
  assign PROG_PHASE               = prog_reg;
  assign SELFTEST_PROG_WE         = st_prog_we_reg;
  assign SELFTEST_RUN_WE          = st_run_we_reg;
  assign SELFTEST_WRITE_ALLOWED   = st_prog_we_reg | st_run_we_reg;

endmodule

// [shared/psc_pkg.sv]
// Shared constants and types of the PSI5 configuration bank
package psc_pkg;

  // ======
  // Register map
  localparam int REG_N      = 12;
  localparam int IDX_CR2    = 0;
  localparam int IDX_CR3    = 1;
  localparam int IDX_SID_LO = 2;
  localparam int IDX_ES1    = 4;
  localparam int IDX_END    = 10;
  localparam int IDX_CH2    = 11;
  localparam logic [5:0] ADDR_DCR = 6'h1E;
  // Addresses by storage index
  localparam logic [5:0] REG_ADDR [REG_N] = '{
    6'h12, 6'h13, 6'h15, 6'h16, 6'h17, 6'h18,
    6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F};
  // Values after any device reset
  localparam logic [15:0] REG_RESET [REG_N] = '{
    16'h0000, 16'h0000, 16'h2D49, 16'h0000, 16'h002C, 16'h00B5,
    16'h8149, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
  // Writable bits; reserved bits are left out
  localparam logic [15:0] REG_MASK [REG_N] = '{
    16'h1FFF, 16'h0FFF, 16'h7FFF, 16'h7FFF, 16'h8FFF, 16'h8FFF,
    16'h8FFF, 16'h8FFF, 16'h8FFF, 16'h8FFF, 16'h8FFF, 16'hBFF7};
  // Slot 2 fields inside the first slot register
  localparam logic [15:0] SLOT2_MASK = 16'h0FC0;

  // ======
  // Field layout
  localparam int SLOT_W       = 6;
  localparam int CNT_W        = 5;
  localparam int SID_W        = 5;
  localparam int TIME_W       = 12;
  localparam int BOOT_OFF_BIT = 12;
  localparam int VSTEP_BIT    = 13;
  localparam int ROLE_BIT     = 12;
  localparam int MON_LSB      = 10;
  localparam int CUR_LSB      = 8;
  localparam int INIT_BIT     = 7;
  localparam int SLOTS_LSB    = 4;
  localparam int RATE_LSB     = 1;
  localparam int SYNC_BIT     = 0;

  // ======
  // Field codes
  localparam logic [4:0] BITS_MIN = 5'h08;
  localparam logic [4:0] BITS_MAX = 5'h1C;
  localparam logic [4:0] BITS_DEF = 5'h14;
  localparam logic [2:0] SLOTS_MIN = 3'h1;
  localparam logic [2:0] SLOTS_MAX = 3'h6;
  localparam logic [2:0] SLOTS_DEF = 3'h3;
  localparam logic [1:0] MON_CODE_STD    = 2'h1;
  localparam logic [1:0] MON_CODE_SIMPLE = 2'h2;
  localparam logic [1:0] CUR_CODE_19     = 2'h0;
  localparam logic [1:0] CUR_CODE_45     = 2'h2;
  localparam logic [1:0] RATE_CODE_189   = 2'h1;
  localparam logic [1:0] RATE_CODE_83    = 2'h2;

  // ======
  // Command values
  localparam logic [15:0] CMD_UNLOCK  = 16'h5555;
  localparam logic [15:0] CMD_RESET   = 16'hA5A5;
  localparam logic [15:0] CMD_CLR_CH1 = 16'h00FF;
  localparam logic [15:0] CMD_CLR_CH2 = 16'hFF00;
  localparam logic [15:0] CMD_EOP     = 16'h1111;
  localparam logic [15:0] CMD_ST_ON   = 16'h9999;
  localparam logic [15:0] CMD_ST_OFF  = 16'h9090;

  // ======
  // Link framing
  localparam logic [4:0] FRAME_LAST = 5'h1F;

  // ======
  // Types
  typedef enum logic {CHECK_CRC, CHECK_PARITY} psc_check_t;
  typedef enum logic {VSTEP_2V5, VSTEP_3V5} psc_volt_t;
  typedef enum logic {PIN_DATA, PIN_IRQ} psc_role_t;
  typedef enum logic [1:0] {MON_OFF, MON_STD, MON_SIMPLE} psc_mon_t;
  typedef enum logic [1:0] {CUR_19MA, CUR_35MA, CUR_45MA} psc_cur_t;
  typedef enum logic [1:0] {RATE_125K, RATE_189K, RATE_83K} psc_rate_t;
  typedef struct packed {
    psc_check_t check;
    logic [4:0] bits;
  } psc_slot_t;
  typedef struct packed {
    logic        wr;
    logic        rsv_a;
    logic [5:0]  addr;
    logic [7:0]  rsv_b;
    logic [15:0] data;
  } psc_frame_t;
  typedef struct packed {
    logic        marker;
    logic        prog;
    logic        st_en;
    logic [6:0]  rsv;
    logic [5:0]  addr;
    logic [15:0] data;
  } psc_resp_t;

endpackage

// [hw/psc_spi_link.sv]
// SPI frame engine on the serial clock with crossing to the system clock
`timescale 1ns/100ps
module psc_spi_link (
  // System side
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // SPI pins
  input  wire logic          sck,
  input  wire logic          cs_n,
  input  wire logic          mosi,
  output logic               miso,
  output logic               miso_oe,
  // Frame hand-over
  output psc_pkg::psc_frame_t rx_frame,
  output logic               rx_valid,
  input  psc_pkg::psc_resp_t tx_resp
);

  logic [4:0]  bit_cnt_reg;  // Bits taken in this frame
  logic [30:0] shift_reg;    // Incoming bits, MSB first
  logic [31:0] word_reg;     // Last complete frame
  logic        tgl_reg;      // Flips once per complete frame
  logic        miso_reg;     // Outgoing bit
  logic        tgl_meta_reg; // Synchroniser stage one
  logic        tgl_sync_reg; // Synchroniser stage two
  logic        tgl_seen_reg; // Last toggle handled
  psc_pkg::psc_frame_t frame_reg;
  logic        valid_reg;

  wire        last_bit = (bit_cnt_reg == psc_pkg::FRAME_LAST);
  wire [31:0] tx_word  = tx_resp;
  wire [4:0]  tx_idx   = ~bit_cnt_reg;
  wire        tgl_edge = tgl_sync_reg ^ tgl_seen_reg;

  // ======
  // Serial clock domain
  // Bit counter, held clear while deselected
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 5'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Shift in on rising edge
  always_ff @(posedge sck) begin
    shift_reg <= {shift_reg[29:0], mosi};
  end

  // Keep the whole word and announce it by a toggle
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 32'h0000_0000;
      tgl_reg  <= 1'b0;
    end else if (last_bit) begin
      word_reg <= {shift_reg, mosi};
      tgl_reg  <= ~tgl_reg;
    end
  end

  // Shift out on falling edge; first bit is the zero marker
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      miso_reg <= 1'b0;
    end else begin
      miso_reg <= tx_word[tx_idx];
    end
  end

  assign miso    = miso_reg;
  assign miso_oe = ~cs_n;

  // ======
  // System clock domain
  // Toggle synchroniser and frame capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      frame_reg    <= '0;
      valid_reg    <= 1'b0;
    end else begin
      tgl_meta_reg <= tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_seen_reg <= tgl_sync_reg;
      valid_reg    <= tgl_edge;
      if (tgl_edge) begin
        frame_reg <= word_reg;
      end
    end
  end

  assign rx_frame = frame_reg;
  assign rx_valid = valid_reg;

endmodule

// [test/psc_spi_host.sv]
// SPI host model sending whole 32-bit frames in mode 0
`timescale 1ns/100ps
module psc_spi_host (
  // SPI pins
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ======
  // Idle bus: clock still, device deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame at a 6 ns bit period, answer taken on each rise
  task automatic xfer(logic [31:0] tx, output logic [31:0] rx);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #3 sck = 1'b1;
      rx[i] = miso;
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    // Released line shows the inverse; gap lets the answer cross
    mosi = ~mosi;
    #120;
  endtask
endmodule

// [test/psc_cfg_regs_assertions.sv]
// Port-level checks of the configuration bank
`timescale 1ns/100ps
module psc_cfg_regs_assertions (
  // Clock and reset
  input wire logic                     CLK_SYS,
  input wire logic                     RST_N,
  // Mode pins and clock fault
  input wire logic                     CH1_KEEP_INIT_FRAMES,
  input wire logic [1:0]               CH1_SLOT_MONITOR_MODE,
  input wire logic                     CH1_SYNCHRONOUS_ON,
  input wire logic                     CLK_FAULT,
  // Settings
  input wire psc_pkg::psc_slot_t [3:0] CH1_SLOT_CFG,
  input wire logic                     CH1_SLOT1_SHARED,
  // Command effects
  input wire logic                     SOFTWARE_TRIGGERED_RESET,
  input wire logic                     CH1_UPSTREAM_CLEAR,
  input wire logic                     CH2_UPSTREAM_CLEAR,
  input wire logic                     PROG_PHASE,
  input wire logic                     SELFTEST_WRITE_ALLOWED,
  input wire logic                     SELFTEST_PROG_WE
);
  // ======
  // Clocking and pulse shape
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_one_shot(s);
    s ##1 !s;
  endsequence
  // ======
  // Checks
  a_reset_one_shot: assert property (
    $rose(SOFTWARE_TRIGGERED_RESET) |-> s_one_shot(SOFTWARE_TRIGGERED_RESET)
  ) else $error("Reset pulse long");
  a_clr1_one_shot: assert property (
    $rose(CH1_UPSTREAM_CLEAR) |-> s_one_shot(CH1_UPSTREAM_CLEAR)
  ) else $error("Clear 1 pulse long");
  a_clr2_one_shot: assert property (
    $rose(CH2_UPSTREAM_CLEAR) |-> s_one_shot(CH2_UPSTREAM_CLEAR)
  ) else $error("Clear 2 pulse long");
  a_reset_prog: assert property (SOFTWARE_TRIGGERED_RESET |->
    ##[0:2] (PROG_PHASE && !SELFTEST_WRITE_ALLOWED)
  ) else $error("Software reset left state");
  a_fault_prog: assert property (CLK_FAULT |=>
    PROG_PHASE && !SELFTEST_WRITE_ALLOWED
  ) else $error("Clock fault left state");
  a_prog_grant: assert property ($rose(SELFTEST_PROG_WE) |->
    PROG_PHASE && SELFTEST_WRITE_ALLOWED
  ) else $error("Prog grant outside phase");
  a_share_cond: assert property (CH1_SLOT1_SHARED ==
    (CH1_KEEP_INIT_FRAMES || CH1_SLOT_MONITOR_MODE == 2'h2
     || !CH1_SYNCHRONOUS_ON)) else $error("Sharing condition wrong");
  a_share_apply: assert property (CH1_SLOT1_SHARED |->
    CH1_SLOT_CFG[1] == CH1_SLOT_CFG[0] && CH1_SLOT_CFG[3] == CH1_SLOT_CFG[0]
  ) else $error("Slot 1 not applied");
endmodule
bind psc_cfg_regs psc_cfg_regs_assertions u_chk (.*);

// [test/psc_cfg_regs_tb.sv]
// Self-checking bench of the configuration bank
`timescale 1ns/100ps
module psc_cfg_regs_tb;
  // ======
  // Signals
  logic                     clk_sys, rst_n, keep_init, sync_on, clk_fault;
  logic [1:0]               mon_mode;
  wire                      sck, cs_n, mosi, miso;
  psc_pkg::psc_slot_t [3:0] slot_cfg;
  psc_pkg::psc_volt_t       volt;
  psc_pkg::psc_role_t       role;
  psc_pkg::psc_mon_t        mon2;
  psc_pkg::psc_cur_t        cur;
  psc_pkg::psc_rate_t       rate;
  logic [2:0]               slots2;
  logic [5:0][4:0]          sid;
  logic [5:0][11:0]         open_t;
  logic [11:0]              close_t;
  logic                     boot, shared, keep2, sync2, sw_rst, clr1, clr2;
  logic                     prog, st_p, st_r, st_a;
  logic [31:0]              rx;
  logic [15:0]              sent;
  int                       n_fail, n_checks, n_rst, n_clr1, n_clr2;
  psc_cfg_regs uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_SCK(sck),
    .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(),
    .CH1_KEEP_INIT_FRAMES(keep_init), .CH1_SLOT_MONITOR_MODE(mon_mode),
    .CH1_SYNCHRONOUS_ON(sync_on), .CLK_FAULT(clk_fault),
    .CH1_BOOTSTRAP_OFF(boot), .CH1_SLOT_CFG(slot_cfg),
    .CH1_SLOT1_SHARED(shared), .CH1_SENSOR_IDENT(sid),
    .CH1_SLOT_OPEN_TIME(open_t), .CH1_LAST_SLOT_CLOSE_TIME(close_t),
    .CH2_PULSE_STEP_VOLT(volt),
    .CH2_OUT_PIN_ROLE(role), .CH2_SLOT_MONITOR_MODE(mon2),
    .CH2_IDLE_CURRENT_LIMIT(cur), .CH2_KEEP_INIT_FRAMES(keep2),
    .CH2_SLOT_COUNT(slots2), .CH2_BIT_RATE(rate),
    .CH2_SYNCHRONOUS_ON(sync2), .SOFTWARE_TRIGGERED_RESET(sw_rst),
    .CH1_UPSTREAM_CLEAR(clr1), .CH2_UPSTREAM_CLEAR(clr2),
    .PROG_PHASE(prog), .SELFTEST_PROG_WE(st_p), .SELFTEST_RUN_WE(st_r),
    .SELFTEST_WRITE_ALLOWED(st_a));
  psc_spi_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // ======
  // Clock, pulse counters and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (sw_rst === 1'b1) n_rst++;
    if (clr1 === 1'b1) n_clr1++;
    if (clr2 === 1'b1) n_clr2++;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(logic w, logic [5:0] a, logic [15:0] d);
    host.xfer({w, 1'b0, a, 8'h00, d}, rx);
    @(negedge clk_sys);
  endtask
  // Answer of a read comes in the following frame
  task automatic rd(logic [5:0] a);
    acc(1'b0, a, 16'h0000);
    acc(1'b0, 6'h00, 16'h0000);
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    sent = {~^d[14:0], d[14:0]};
    acc(1'b1, a, sent);
  endtask
  task automatic cmd(logic [15:0] d);
    acc(1'b1, psc_pkg::ADDR_DCR, d);
  endtask
  // ======
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < psc_pkg::REG_N; i++) begin
      rd(psc_pkg::REG_ADDR[i]);
      chk("reset", 32'(rx[15:0]), 32'(psc_pkg::REG_RESET[i]));
    end
    rd(psc_pkg::ADDR_DCR);
    chk("dcr read", 32'({rx[30], rx[15:0]}), 32'h10000);
    chk("ids", 32'({sid[2], sid[1], sid[0]}), 32'h2D49);
    chk("times", 32'({open_t[2], close_t}), 32'h149000);
    $display("reset test done");
  endtask
  task automatic t_mask();
    for (int i = 0; i < psc_pkg::REG_N; i++) begin
      wr(psc_pkg::REG_ADDR[i], 16'hFFFF);
      rd(psc_pkg::REG_ADDR[i]);
      chk("mask", 32'(rx[15:0]), 32'(sent & psc_pkg::REG_MASK[i]));
    end
    chk("boot and check", 32'({boot, slot_cfg[0].check}), 32'h3);
    $display("mask test done");
  endtask
  task automatic t_codes();
    logic [2:0] k;
    logic [1:0] m;
    for (int i = 7; i <= 29; i++) begin
      wr(6'h12, {11'h000, 5'(i)});
      chk("bits", 32'(slot_cfg[0].bits), (i < 8 || i > 28) ? 20 : i);
    end
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      m = (k[1:0] == 2'h3) ? 2'h0 : k[1:0];
      wr(6'h1F, {2'b00, k[0], k[0], k[1:0], k[1:0], k[0], k, 1'b0, k[1:0], k[0]});
      chk("bits1", 32'({volt, role, keep2, sync2}), {28'h0, {4{k[0]}}});
      chk("mon rate", 32'({mon2, rate}), 32'({m, m}));
      chk("current", 32'(cur), (k[1:0] == 2'h3) ? 1 : 32'(k[1:0]));
      chk("slots", 32'(slots2), (k == 3'h0 || k == 3'h7) ? 3 : 32'(k));
    end
    $display("code test done");
  endtask
  task automatic t_share();
    wr(6'h12, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      keep_init <= (i == 0);
      mon_mode <= (i == 1) ? 2'h2 : 2'h1;
      sync_on <= (i == 1 || i == 3);
      @(negedge clk_sys);
      chk("shared", 32'(shared), 32'(i != 3));
    end
    wr(6'h13, 16'h0000);
    wr(6'h12, 16'h0000);
    chk("slot6 use", 32'(slot_cfg[3]), 32'h14);
    rd(6'h13);
    chk("held", 32'(rx[15:0]), 32'h0FFF);
    rd(6'h12);
    chk("slot2 held", 32'(rx[15:0]), 32'(psc_pkg::SLOT2_MASK));
    $display("share test done");
  endtask
  task automatic t_cmd();
    cmd(psc_pkg::CMD_CLR_CH1);
    cmd(psc_pkg::CMD_CLR_CH2);
    chk("clears", 32'(n_clr1 * 16 + n_clr2), 32'h11);
    cmd(psc_pkg::CMD_UNLOCK);
    rd(6'h17);
    cmd(psc_pkg::CMD_RESET);
    chk("no reset", 32'(n_rst), 0);
    cmd(psc_pkg::CMD_ST_ON);
    chk("st on", 32'({st_p, st_r, st_a}), 32'h7);
    cmd(psc_pkg::CMD_ST_OFF);
    chk("st off", 32'({st_p, st_r, st_a}), 32'h0);
    cmd(psc_pkg::CMD_EOP);
    wr(6'h1D, 16'h0123);
    rd(6'h1D);
    chk("locked", 32'({rx[30], rx[15:0]}), 32'h0FFF);
    cmd(psc_pkg::CMD_ST_ON);
    chk("run only", 32'({st_p, st_r}), 32'h1);
    @(posedge clk_sys);
    clk_fault <= 1'b1;
    @(posedge clk_sys);
    clk_fault <= 1'b0;
    @(negedge clk_sys);
    chk("fault", 32'({prog, st_a}), 32'h2);
    wr(6'h1D, 16'h0123);
    cmd(psc_pkg::CMD_EOP);
    cmd(psc_pkg::CMD_UNLOCK);
    cmd(psc_pkg::CMD_RESET);
    rd(6'h1D);
    chk("software_triggered_reset", 32'(n_rst), 1);
    chk("reset regs", 32'({rx[30], rx[15:0]}), 32'h18000);
    $display("command test done");
  endtask
  // ======
  // Main sequence, watchdog and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, keep_init, mon_mode, clk_fault} = '0;
    sync_on = 1'b1;
    {n_fail, n_checks, n_rst, n_clr1, n_clr2} = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_mask();
    t_codes();
    t_share();
    t_cmd();
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule
